// File: hrs_pkg.sv
// shared constants of the hall result and status register bank
package hrs_pkg;
    localparam int BYTE_W = 8;
    localparam int AXIS_W = 16;
    localparam int ANGLE_W = 13;
    localparam int ANGLE_HI_W = ANGLE_W - BYTE_W;
    localparam int CNT_W = 3;
    localparam int ERR_W = 4;
    localparam int BIT_CNT_W = 4;

    localparam logic [7:0] OFS_X_HIGH = 8'h12;
    localparam logic [7:0] OFS_X_LOW = 8'h13;
    localparam logic [7:0] OFS_Y_HIGH = 8'h14;
    localparam logic [7:0] OFS_Y_LOW = 8'h15;
    localparam logic [7:0] OFS_Z_HIGH = 8'h16;
    localparam logic [7:0] OFS_Z_LOW = 8'h17;
    localparam logic [7:0] OFS_CONV_STATE = 8'h18;
    localparam logic [7:0] OFS_ANGLE_HIGH = 8'h19;
    localparam logic [7:0] OFS_ANGLE_LOW = 8'h1a;
    localparam logic [7:0] OFS_MAGNITUDE = 8'h1b;
    localparam logic [7:0] OFS_DEV_STATE = 8'h1c;

    // conversion_state field positions
    localparam int CS_CNT_MSB = 7;
    localparam int CS_CNT_LSB = 5;
    localparam int CS_POR_BIT = 4;
    localparam int CS_DIAG_BIT = 1;
    localparam int CS_READY_BIT = 0;
    localparam logic [7:0] CONV_STATE_RESET = 8'h10;

    // device state error flag positions
    localparam int DS_OSC_BIT = 3;
    localparam int DS_IRQ_PIN_BIT = 2;
    localparam int DS_CHECKSUM_BIT = 1;
    localparam int DS_UNDERVOLT_BIT = 0;

    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;
    localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h35;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_PTR,
        ST_WR_ACK,
        ST_WDATA,
        ST_RDATA,
        ST_RACK
    } hrs_state_t;
endpackage

// File: hrs_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module hrs_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_en,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_q;

    always_comb
    begin
        nxt_meta = meta_ff;
        nxt_q = q_ff;
        if (i_en)
        begin
            nxt_meta = i_d;
            nxt_q = meta_ff;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_ff <= '1;
            q_ff <= '1;
        end
        else
        begin
            meta_ff <= nxt_meta;
            q_ff <= nxt_q;
        end
    end

    assign o_q = q_ff;
endmodule

// File: hrs_top.sv
// result and status register bank with its serial management slave
`timescale 1ns/10ps
module hrs_top
    import hrs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEFAULT_DEV_ADDR
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic I_CLK_EN,
    input wire logic I_SCL,
    input wire logic I_SDA,
    output logic O_SDA_OUT,
    output logic O_SDA_OE,
    input wire logic I_SET_DONE,
    input wire logic I_CONV_START,
    input wire logic [AXIS_W-1:0] I_X_AXIS_VALUE,
    input wire logic [AXIS_W-1:0] I_Y_AXIS_VALUE,
    input wire logic [AXIS_W-1:0] I_Z_AXIS_VALUE,
    input wire logic [ANGLE_W-1:0] I_ANGLE_VALUE,
    input wire logic [BYTE_W-1:0] I_MAGNITUDE_VALUE,
    input wire logic I_OSCILLATOR_ERROR_DET,
    input wire logic I_IRQ_PIN_ERROR_DET,
    input wire logic I_MEMORY_CHECKSUM_ERROR_DET,
    input wire logic I_UNDERVOLTAGE_ERROR_DET
);
    logic scl_s, sda_s, scl_prev_ff, sda_prev_ff, nxt_scl_prev, nxt_sda_prev;
    logic scl_rise, scl_fall, start_cond, stop_cond;

    hrs_state_t state_ff, nxt_state;
    logic [BIT_CNT_W-1:0] bit_cnt_ff, nxt_bit_cnt;
    logic [BYTE_W-1:0] rx_ff, nxt_rx, tx_ff, nxt_tx, ptr_ff, nxt_ptr;
    logic rw_ff, nxt_rw, nack_ff, nxt_nack, sda_oe_ff, nxt_sda_oe, sda_out_ff;

    logic wr_en;
    logic [BYTE_W-1:0] wr_addr, rd_data;

    logic [AXIS_W-1:0] x_ff, y_ff, z_ff, nxt_x, nxt_y, nxt_z;
    logic [ANGLE_W-1:0] angle_ff, nxt_angle;
    logic [BYTE_W-1:0] mag_ff, nxt_mag;
    logic [CNT_W-1:0] set_cnt_ff, nxt_set_cnt;
    logic por_ff, ready_ff, nxt_por, nxt_ready, por_clr, diag_fail;
    logic [ERR_W-1:0] err_ff, nxt_err, err_det, err_clr;

    hrs_sync #(
        .W(2)
    ) u_pin_sync (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_en(I_CLK_EN),
        .i_d({I_SCL, I_SDA}),
        .o_q({scl_s, sda_s})
    );

    // bus condition detection on the synchronised lines
    assign scl_rise = scl_s & ~scl_prev_ff;
    assign scl_fall = ~scl_s & scl_prev_ff;
    assign start_cond = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
    assign stop_cond = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;

    // read data for the current pointer; unmapped offsets read zero
    always_comb
    begin
        rd_data = RESULT_RESET;
        case (ptr_ff)
            OFS_X_HIGH: rd_data = x_ff[AXIS_W-1:BYTE_W];
            OFS_X_LOW: rd_data = x_ff[BYTE_W-1:0];
            OFS_Y_HIGH: rd_data = y_ff[AXIS_W-1:BYTE_W];
            OFS_Y_LOW: rd_data = y_ff[BYTE_W-1:0];
            OFS_Z_HIGH: rd_data = z_ff[AXIS_W-1:BYTE_W];
            OFS_Z_LOW: rd_data = z_ff[BYTE_W-1:0];
            OFS_CONV_STATE:
            begin
                rd_data[CS_CNT_MSB:CS_CNT_LSB] = set_cnt_ff;
                rd_data[CS_POR_BIT] = por_ff;
                rd_data[CS_DIAG_BIT] = diag_fail;
                rd_data[CS_READY_BIT] = ready_ff;
            end
            // upper three bits of the angle high byte stay zero
            OFS_ANGLE_HIGH: rd_data[ANGLE_HI_W-1:0] = angle_ff[ANGLE_W-1:BYTE_W];
            OFS_ANGLE_LOW: rd_data = angle_ff[BYTE_W-1:0];
            OFS_MAGNITUDE: rd_data = mag_ff;
            OFS_DEV_STATE: rd_data[ERR_W-1:0] = err_ff;
            default: rd_data = RESULT_RESET;
        endcase
    end

    // serial slave: address, pointer, then write or auto-incrementing read
    always_comb
    begin
        nxt_scl_prev = scl_prev_ff;
        nxt_sda_prev = sda_prev_ff;
        nxt_state = state_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_rx = rx_ff;
        nxt_tx = tx_ff;
        nxt_ptr = ptr_ff;
        nxt_rw = rw_ff;
        nxt_nack = nack_ff;
        nxt_sda_oe = sda_oe_ff;
        wr_en = 1'b0;
        wr_addr = ptr_ff;
        if (I_CLK_EN)
        begin
            nxt_scl_prev = scl_s;
            nxt_sda_prev = sda_s;
            if (start_cond)
            begin
                nxt_state = ST_ADDR;
                nxt_bit_cnt = '0;
                nxt_sda_oe = 1'b0;
            end
            else if (stop_cond)
            begin
                nxt_state = ST_IDLE;
                nxt_sda_oe = 1'b0;
            end
            else
            begin
                case (state_ff)
                    ST_IDLE:
                    begin
                        nxt_sda_oe = 1'b0;
                    end
                    ST_ADDR, ST_PTR, ST_WDATA:
                    begin
                        if (scl_rise)
                        begin
                            nxt_rx = {rx_ff[BYTE_W-2:0], sda_s};
                            nxt_bit_cnt = bit_cnt_ff + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_ff == BITS_PER_BYTE)
                        begin
                            nxt_bit_cnt = '0;
                            nxt_sda_oe = 1'b1;
                            if (state_ff == ST_ADDR)
                            begin
                                nxt_rw = rx_ff[0];
                                nxt_state = ST_ADDR_ACK;
                                if (rx_ff[BYTE_W-1:1] != DEV_ADDR)
                                begin
                                    nxt_state = ST_IDLE;
                                    nxt_sda_oe = 1'b0;
                                end
                            end
                            else if (state_ff == ST_PTR)
                            begin
                                nxt_ptr = rx_ff;
                                nxt_state = ST_WR_ACK;
                            end
                            else
                            begin
                                wr_en = 1'b1;
                                nxt_ptr = ptr_ff + 8'h01;
                                nxt_state = ST_WR_ACK;
                            end
                        end
                    end
                    ST_ADDR_ACK:
                    begin
                        if (scl_fall)
                        begin
                            if (rw_ff)
                            begin
                                nxt_tx = rd_data;
                                nxt_sda_oe = ~rd_data[BYTE_W-1];
                                nxt_ptr = ptr_ff + 8'h01;
                                nxt_state = ST_RDATA;
                            end
                            else
                            begin
                                nxt_sda_oe = 1'b0;
                                nxt_state = ST_PTR;
                            end
                        end
                    end
                    ST_WR_ACK:
                    begin
                        if (scl_fall)
                        begin
                            nxt_sda_oe = 1'b0;
                            nxt_state = ST_WDATA;
                        end
                    end
                    ST_RDATA:
                    begin
                        if (scl_rise)
                        begin
                            nxt_bit_cnt = bit_cnt_ff + 4'h1;
                        end
                        else if (scl_fall)
                        begin
                            if (bit_cnt_ff == BITS_PER_BYTE)
                            begin
                                nxt_bit_cnt = '0;
                                nxt_sda_oe = 1'b0;
                                nxt_state = ST_RACK;
                            end
                            else
                            begin
                                nxt_tx = {tx_ff[BYTE_W-2:0], 1'b0};
                                nxt_sda_oe = ~tx_ff[BYTE_W-2];
                            end
                        end
                    end
                    ST_RACK:
                    begin
                        if (scl_rise)
                        begin
                            nxt_nack = sda_s;
                        end
                        else if (scl_fall)
                        begin
                            if (nack_ff)
                            begin
                                nxt_state = ST_IDLE;
                            end
                            else
                            begin
                                nxt_tx = rd_data;
                                nxt_sda_oe = ~rd_data[BYTE_W-1];
                                nxt_ptr = ptr_ff + 8'h01;
                                nxt_state = ST_RDATA;
                            end
                        end
                    end
                    default:
                    begin
                        nxt_state = ST_IDLE;
                        nxt_sda_oe = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
            state_ff <= ST_IDLE;
            bit_cnt_ff <= '0;
            rx_ff <= '0;
            tx_ff <= '0;
            ptr_ff <= '0;
            rw_ff <= 1'b0;
            nack_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            sda_out_ff <= 1'b0;
        end
        else
        begin
            scl_prev_ff <= nxt_scl_prev;
            sda_prev_ff <= nxt_sda_prev;
            state_ff <= nxt_state;
            bit_cnt_ff <= nxt_bit_cnt;
            rx_ff <= nxt_rx;
            tx_ff <= nxt_tx;
            ptr_ff <= nxt_ptr;
            rw_ff <= nxt_rw;
            nack_ff <= nxt_nack;
            sda_oe_ff <= nxt_sda_oe;
            sda_out_ff <= 1'b0;
        end
    end

    // write-one-to-clear strobes; any other written bit is dropped
    always_comb
    begin
        err_clr = '0;
        por_clr = 1'b0;
        if (wr_en && wr_addr == OFS_CONV_STATE)
        begin
            por_clr = rx_ff[CS_POR_BIT];
        end
        if (wr_en && wr_addr == OFS_DEV_STATE)
        begin
            err_clr = rx_ff[ERR_W-1:0];
        end
    end

    assign err_det[DS_OSC_BIT] = I_OSCILLATOR_ERROR_DET;
    assign err_det[DS_IRQ_PIN_BIT] = I_IRQ_PIN_ERROR_DET;
    assign err_det[DS_CHECKSUM_BIT] = I_MEMORY_CHECKSUM_ERROR_DET;
    assign err_det[DS_UNDERVOLT_BIT] = I_UNDERVOLTAGE_ERROR_DET;
    assign diag_fail = |err_ff;

    // result capture and status flags
    always_comb
    begin
        nxt_x = x_ff;
        nxt_y = y_ff;
        nxt_z = z_ff;
        nxt_angle = angle_ff;
        nxt_mag = mag_ff;
        nxt_set_cnt = set_cnt_ff;
        nxt_por = por_ff;
        nxt_ready = ready_ff;
        nxt_err = err_ff;
        if (I_CLK_EN)
        begin
            // a detection in the clearing cycle keeps the flag set
            nxt_err = (err_ff & ~err_clr) | err_det;
            nxt_por = por_ff & ~por_clr;
            if (I_CONV_START)
            begin
                nxt_ready = 1'b0;
            end
            if (I_SET_DONE)
            begin
                nxt_x = I_X_AXIS_VALUE;
                nxt_y = I_Y_AXIS_VALUE;
                nxt_z = I_Z_AXIS_VALUE;
                nxt_angle = I_ANGLE_VALUE;
                nxt_mag = I_MAGNITUDE_VALUE;
                nxt_set_cnt = set_cnt_ff + 3'h1;
                nxt_ready = 1'b1;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            x_ff <= {RESULT_RESET, RESULT_RESET};
            y_ff <= {RESULT_RESET, RESULT_RESET};
            z_ff <= {RESULT_RESET, RESULT_RESET};
            angle_ff <= '0;
            mag_ff <= RESULT_RESET;
            set_cnt_ff <= CONV_STATE_RESET[CS_CNT_MSB:CS_CNT_LSB];
            por_ff <= CONV_STATE_RESET[CS_POR_BIT];
            ready_ff <= CONV_STATE_RESET[CS_READY_BIT];
            err_ff <= '0;
        end
        else
        begin
            x_ff <= nxt_x;
            y_ff <= nxt_y;
            z_ff <= nxt_z;
            angle_ff <= nxt_angle;
            mag_ff <= nxt_mag;
            set_cnt_ff <= nxt_set_cnt;
            por_ff <= nxt_por;
            ready_ff <= nxt_ready;
            err_ff <= nxt_err;
        end
    end

    assign O_SDA_OUT = sda_out_ff;
    assign O_SDA_OE = sda_oe_ff;
endmodule

// File: hrs_top_properties.sv
// checker on the serial pins of the result and status register bank
`timescale 1ns/10ps
module hrs_props
    import hrs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEFAULT_DEV_ADDR
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic I_SCL,
    input wire logic I_SDA,
    input wire logic O_SDA_OUT,
    input wire logic O_SDA_OE
);
    logic scl_ff, sda_ff, frame_ff, rise, start, stop, hit, slot;
    logic [3:0] bit_ff;
    logic [1:0] byte_ff;
    logic [7:0] addr_ff;
    assign rise = I_SCL && !scl_ff;
    assign start = I_SCL && scl_ff && sda_ff && !I_SDA;
    assign stop = I_SCL && scl_ff && !sda_ff && I_SDA;
    assign hit = addr_ff[7:1] == DEV_ADDR;
    assign slot = rise && frame_ff && bit_ff == 4'h8;
    // shadow of the bus framing, seen on the raw pins
    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
            frame_ff <= 1'b0;
            bit_ff <= 4'h0;
            byte_ff <= 2'h0;
            addr_ff <= 8'h00;
        end
        else
        begin
            scl_ff <= I_SCL;
            sda_ff <= I_SDA;
            if (start)
            begin
                frame_ff <= 1'b1;
                bit_ff <= 4'h0;
                byte_ff <= 2'h0;
            end
            else if (stop)
                frame_ff <= 1'b0;
            else if (rise && frame_ff)
            begin
                bit_ff <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
                if (bit_ff == 4'h8 && byte_ff != 2'h3)
                    byte_ff <= byte_ff + 2'h1;
                if (byte_ff == 2'h0 && bit_ff != 4'h8)
                    addr_ff <= {addr_ff[6:0], I_SDA};
            end
        end
    end
    default clocking dcb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RST);
    AST_OUT_ZERO: assert property (O_SDA_OUT == 1'b0)
        else $error("sda data value not zero");
    AST_OE_STABLE_SCL_HIGH: assert property (I_SCL [*3] |-> $stable(O_SDA_OE))
        else $error("sda drive changed while scl high");
    AST_OE_RISE_SCL_LOW: assert property ($rose(O_SDA_OE) |-> !I_SCL && !$past(I_SCL))
        else $error("sda drive started outside scl low");
    AST_RESET_QUIET: assert property ($fell(I_RST) |-> !O_SDA_OE ##1 !O_SDA_OE)
        else $error("sda driven right after reset");
    AST_ADDR_QUIET: assert property (frame_ff && byte_ff == 2'h0 && bit_ff != 4'h8 |-> !O_SDA_OE)
        else $error("sda driven during address byte");
    AST_ACK_MATCH: assert property (slot && byte_ff == 2'h0 && hit |-> O_SDA_OE)
        else $error("own address not acknowledged");
    AST_NO_ACK_OTHER: assert property (frame_ff && !hit && (byte_ff != 2'h0 || bit_ff == 4'h8)
        |-> !O_SDA_OE)
        else $error("foreign address answered");
    AST_ACK_WRITE: assert property (slot && byte_ff != 2'h0 && hit && !addr_ff[0] |-> O_SDA_OE)
        else $error("written byte not acknowledged");
    AST_READ_RELEASE: assert property (slot && byte_ff != 2'h0 && hit && addr_ff[0] |-> !O_SDA_OE)
        else $error("sda not released for host ack");
    cover property (slot && byte_ff == 2'h0 && hit && addr_ff[0]);
    cover property (slot && byte_ff == 2'h0 && !hit);
    cover property (slot && byte_ff == 2'h2 && hit && !addr_ff[0]);
endmodule

bind hrs_top hrs_props #(.DEV_ADDR(DEV_ADDR)) u_props (
    .I_SYS_CLK(I_SYS_CLK),
    .I_RST(I_RST),
    .I_SCL(I_SCL),
    .I_SDA(I_SDA),
    .O_SDA_OUT(O_SDA_OUT),
    .O_SDA_OE(O_SDA_OE)
);

// File: hrs_host_model.sv
// host controller model driving the serial management pins
`timescale 1ns/10ps
module hrs_host_model
    import hrs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEFAULT_DEV_ADDR
) (
    input wire logic i_clk,
    input wire logic i_sda_line,
    output logic o_scl,
    output logic o_sda_rel
);
    initial
    begin
        o_scl = 1'b1;
        o_sda_rel = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // data moves only mid-way through scl low, leaving setup and hold margin
    task automatic wr_bit(input logic b);
        o_sda_rel = b;
        tick(5);
        o_scl = 1'b1;
        tick(10);
        o_scl = 1'b0;
        tick(5);
    endtask
    task automatic rd_bit(output logic b);
        o_sda_rel = 1'b1;
        tick(5);
        o_scl = 1'b1;
        tick(5);
        b = i_sda_line;
        tick(5);
        o_scl = 1'b0;
        tick(5);
    endtask
    task automatic start_c();
        o_sda_rel = 1'b1;
        tick(5);
        o_scl = 1'b1;
        tick(10);
        o_sda_rel = 1'b0;
        tick(10);
        o_scl = 1'b0;
        tick(5);
    endtask
    task automatic stop_c();
        o_sda_rel = 1'b0;
        tick(5);
        o_scl = 1'b1;
        tick(10);
        o_sda_rel = 1'b1;
        tick(10);
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--)
            wr_bit(d[i]);
        rd_bit(ack);
    endtask
    task automatic probe(input logic [6:0] adr, output logic ack);
        start_c();
        wr_byte({adr, 1'b0}, ack);
        stop_c();
    endtask
    // writing ones is how the host clears the sticky flags
    task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] d);
        logic a;
        start_c();
        wr_byte({DEV_ADDR, 1'b0}, a);
        wr_byte(ofs, a);
        wr_byte(d, a);
        stop_c();
    endtask
    task automatic rd_reg(input logic [7:0] ofs, output logic [7:0] d);
        logic a;
        logic b;
        start_c();
        wr_byte({DEV_ADDR, 1'b0}, a);
        wr_byte(ofs, a);
        start_c();
        wr_byte({DEV_ADDR, 1'b1}, a);
        for (int i = 7; i >= 0; i--)
        begin
            rd_bit(b);
            d[i] = b;
        end
        wr_bit(1'b1);
        stop_c();
    endtask
endmodule

// File: hrs_top_tb.sv
// self-checking bench for the result and status register bank
`timescale 1ns/10ps
module hrs_top_tb;
    localparam int TIMEOUT = 80000;
    logic clk, rst, scl, sda_rel, sda_oe, sda_out, set_done, conv_start, a, clk_en;
    logic [15:0] xv, yv, zv;
    logic [12:0] ang;
    logic [7:0] mag;
    logic [3:0] errs;
    logic [7:0] exp_tab [0:9];
    int err_count, checks_done, cyc;
    wire sda_line = sda_rel & ~sda_oe;
    always #2 clk = ~clk;
    hrs_top uut (
        .I_SYS_CLK(clk),
        .I_RST(rst),
        .I_CLK_EN(clk_en),
        .I_SCL(scl),
        .I_SDA(sda_line),
        .O_SDA_OUT(sda_out),
        .O_SDA_OE(sda_oe),
        .I_SET_DONE(set_done),
        .I_CONV_START(conv_start),
        .I_X_AXIS_VALUE(xv),
        .I_Y_AXIS_VALUE(yv),
        .I_Z_AXIS_VALUE(zv),
        .I_ANGLE_VALUE(ang),
        .I_MAGNITUDE_VALUE(mag),
        .I_OSCILLATOR_ERROR_DET(errs[3]),
        .I_IRQ_PIN_ERROR_DET(errs[2]),
        .I_MEMORY_CHECKSUM_ERROR_DET(errs[1]),
        .I_UNDERVOLTAGE_ERROR_DET(errs[0])
    );
    hrs_host_model host (.i_clk(clk), .i_sda_line(sda_line), .o_scl(scl), .o_sda_rel(sda_rel));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rc(input logic [7:0] ofs, input logic [7:0] exp);
        logic [7:0] v;
        host.rd_reg(ofs, v);
        check(v, exp);
    endtask
    // one-cycle pulse on {set_done, conv_start, errs}
    task automatic pulse(input logic [5:0] m);
        @(posedge clk);
        #1 {set_done, conv_start, errs} = m;
        @(posedge clk);
        #1 {set_done, conv_start, errs} = 6'h00;
    endtask
    task automatic do_reset();
        rst = 1'b1;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic summarize();
        $display("errors %0d, checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == TIMEOUT)
        begin
            err_count++;
            summarize();
        end
    end
    initial
    begin
        clk = 1'b0;
        clk_en = 1'b1;
        {set_done, conv_start, errs} = 6'h00;
        xv = 16'h8001;
        yv = 16'h7ffe;
        zv = 16'hc35a;
        ang = 13'h1679;
        mag = 8'hb4;
        err_count = 0;
        checks_done = 0;
        cyc = 0;
        do_reset();
        for (int i = 8'h11; i <= 8'h1d; i++)
            rc(8'(i), (i == 8'h18) ? 8'h10 : 8'h00);
        host.probe(7'h12, a);
        check({7'h00, a}, 8'h01);
        pulse(6'h20);
        exp_tab = '{xv[15:8], xv[7:0], yv[15:8], yv[7:0], zv[15:8], zv[7:0], 8'h31,
            {3'h0, ang[12:8]}, ang[7:0], mag};
        xv = 16'h0000;
        for (int i = 0; i < 10; i++)
            rc(8'h12 + 8'(i), exp_tab[i]);
        host.wr_reg(8'h12, 8'hff);
        host.wr_reg(8'h18, 8'hef);
        rc(8'h12, exp_tab[0]);
        rc(8'h18, 8'h31);
        host.wr_reg(8'h18, 8'h10);
        rc(8'h18, 8'h21);
        pulse(6'h10);
        rc(8'h18, 8'h20);
        for (int i = 0; i < 7; i++)
            pulse(6'h20);
        rc(8'h18, 8'h01);
        pulse(6'h30);
        rc(8'h18, 8'h21);
        for (int i = 0; i < 4; i++)
        begin
            pulse(6'(1 << i));
            rc(8'h18, 8'h23);
            host.wr_reg(8'h1c, ~8'(1 << i));
            rc(8'h1c, 8'(1 << i));
            host.wr_reg(8'h1c, 8'(1 << i));
            rc(8'h18, 8'h21);
        end
        // a data set arriving while the clock enable is low must be dropped
        clk_en = 1'b0;
        pulse(6'h20);
        clk_en = 1'b1;
        rc(8'h18, 8'h21);
        do_reset();
        rc(8'h18, 8'h10);
        rc(8'h12, 8'h00);
        summarize();
    end
endmodule
